// [hw/cwf_core.sv]
// Notes on behaviour
// - A call pushes the address after the call onto the return stack.
// - A call loads its 8-bit literal into program counter bits 7:0.
// - A call copies status bits 6:5 to counter bits 10:9, clears bit 8.
// - A call takes two cycles and changes no status flag.
// - Watchdog clear sets the watchdog count to zero.
// - Watchdog clear zeroes the prescaler only when the watchdog owns it.
// - Watchdog clear sets both active-low timeout and powerdown flags.
// - File clear writes zero to the register and sets the zero flag.
// - File invert complements the register and updates the zero flag.
// - Destination select 0 writes the accumulator, 1 the file register.
// - File decrement subtracts one modulo 256 and updates the zero flag.
// - File increment adds one modulo 256 and updates the zero flag.
// - Decrement-skip stores the decrement and leaves all flags alone.
// - A zero decrement-skip discards the prefetched word, taking two cycles.
`timescale 1ns/100ps
`default_nettype none
`include "cwf_map.svh"

module cwf_core
  import cwf_pkg::*;
#(
  parameter int STACK_DEPTH = 2,
  parameter int PC_W        = 11,
  parameter int FILE_DEPTH  = 32
)(
  input  wire logic            sys_clk_in,
  input  wire logic            sys_rst_in,
  input  wire logic [11:0]     instr_in,
  input  wire logic            instr_valid_in,
  input  wire logic            wdt_tick_in,
  input  wire logic            tmr_tick_in,
  input  wire logic [5:0]      bus_addr_in,
  input  wire logic [7:0]      bus_wdata_in,
  input  wire logic            bus_wr_in,
  input  wire logic            bus_rd_in,
  output var  logic            instr_ready_out,
  output var  logic            flush_out,
  output var  logic [PC_W-1:0] pc_out,
  output var  logic [PC_W-1:0] stack_top_out,
  output var  logic [7:0]      w_out,
  output var  logic [7:0]      status_out,
  output var  logic [7:0]      wdt_count_out,
  output var  logic [7:0]      prescaler_out,
  output var  logic [7:0]      bus_rdata_out
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]      file_mem [FILE_DEPTH];
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [7:0]      ctrl;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  cwf_op_t         op;
  logic            take;
  logic [4:0]      file_addr;
  logic            dest_file;
  logic [7:0]      lit;
  logic [7:0]      file_rd;
  logic [7:0]      alu_result;
  logic            alu_zero;
  logic            alu_z_upd;
  logic            alu_file_op;
  logic            do_skip;
  logic            do_call;
  logic            do_wclr;
  logic            psa;
  logic [PC_W-1:0] pc_plus1;
  logic [PC_W-1:0] next_pc;

  always_comb begin
    op = CWF_OP_NOP;
    if ((instr_in & `CWF_ENC_CALL_MASK) == `CWF_ENC_CALL_VAL) begin
      op = CWF_OP_CALL;
    end else if (instr_in == `CWF_ENC_WCLR_VAL) begin
      op = CWF_OP_WCLR;
    end else if ((instr_in & `CWF_ENC_CLR_MASK) == `CWF_ENC_CLR_VAL) begin
      op = CWF_OP_CLR;
    end else if ((instr_in & `CWF_ENC_FOP_MASK) == `CWF_ENC_INV_VAL) begin
      op = CWF_OP_INV;
    end else if ((instr_in & `CWF_ENC_FOP_MASK) == `CWF_ENC_DEC_VAL) begin
      op = CWF_OP_DEC;
    end else if ((instr_in & `CWF_ENC_FOP_MASK) == `CWF_ENC_INC_VAL) begin
      op = CWF_OP_INC;
    end else if ((instr_in & `CWF_ENC_FOP_MASK) == `CWF_ENC_DECSZ_VAL) begin
      op = CWF_OP_DECSZ;
    end
  end

  assign take      = instr_valid_in & instr_ready_out;
  assign file_addr = instr_in[`CWF_FA_MSB:0];
  // Clear has no destination bit; it always targets the file
  assign dest_file = instr_in[`CWF_DEST_BIT] | (op == CWF_OP_CLR);
  assign lit       = instr_in[`CWF_LIT_MSB:0];
  assign file_rd   = file_mem[file_addr];
  assign psa       = ctrl[`CWF_CTRL_PSA];
  assign pc_plus1  = pc_out + 1'b1;

  cwf_file_alu u_alu (
    .op_in          (op),
    .operand_in     (file_rd),
    .result_out     (alu_result),
    .zero_out       (alu_zero),
    .z_upd_out      (alu_z_upd),
    .is_file_op_out (alu_file_op)
  );

  assign do_call = take & (op == CWF_OP_CALL);
  assign do_wclr = take & (op == CWF_OP_WCLR);
  assign do_skip = take & (op == CWF_OP_DECSZ) & alu_zero;

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  always_comb begin
    next_pc = pc_out;
    if (do_call) begin
      next_pc = pc_out;
      next_pc[`CWF_LIT_MSB:0] = lit;
      next_pc[`CWF_PC_BIT8] = 1'b0;
      next_pc[PC_W-1:PC_W-2] =
        status_out[`CWF_ST_PG_MSB:`CWF_ST_PG_LSB];
    end else if (do_skip) begin
      // The discarded word is stepped over as well
      next_pc = pc_out + 2'd2;
    end else if (take) begin
      next_pc = pc_plus1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pc_out <= '0;
    end else begin
      pc_out <= next_pc;
    end
  end

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  // Oldest entry falls off the bottom when the stack is full
  genvar gi;
  generate
    for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
      always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          stack_mem[gi] <= '0;
        end else if (do_call) begin
          if (gi == 0) begin
            stack_mem[gi] <= pc_plus1;
          end else begin
            stack_mem[gi] <= stack_mem[(gi > 0) ? gi-1 : 0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stack_top_out <= '0;
    end else if (do_call) begin
      stack_top_out <= pc_plus1;
    end
  end

  // ----------------------------------------------------------------
  // Fetch handshake
  // ----------------------------------------------------------------
  // Second cycle of a call or skip: the prefetched word is dropped
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      instr_ready_out <= 1'b0;
      flush_out       <= 1'b0;
    end else begin
      instr_ready_out <= !(do_call || do_skip);
      flush_out       <= do_call || do_skip;
    end
  end

  // ----------------------------------------------------------------
  // File registers
  // ----------------------------------------------------------------
  // Instruction writes win over a port write in the same cycle
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_mem[i] <= 8'h00;
      end
    end else if (take && alu_file_op && dest_file) begin
      file_mem[file_addr] <= alu_result;
    end else if (bus_wr_in && bus_addr_in <= `CWF_ADDR_FILE_TOP) begin
      file_mem[bus_addr_in[4:0]] <= bus_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      w_out <= 8'h00;
    end else if (take && alu_file_op && !dest_file) begin
      w_out <= alu_result;
    end else if (bus_wr_in && bus_addr_in == `CWF_ADDR_ACC) begin
      w_out <= bus_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog and prescaler
  // ----------------------------------------------------------------
  logic wdt_sync1;
  logic wdt_sync2;
  logic wdt_prev;
  logic wdt_edge;
  logic pre_tick;
  logic pre_clr;
  logic wdt_inc;
  logic wdt_ovf;

  // The tick comes from a free-running oscillator of its own
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wdt_sync1 <= 1'b0;
      wdt_sync2 <= 1'b0;
      wdt_prev  <= 1'b0;
    end else begin
      wdt_sync1 <= wdt_tick_in;
      wdt_sync2 <= wdt_sync1;
      wdt_prev  <= wdt_sync2;
    end
  end

  assign wdt_edge = wdt_sync2 & ~wdt_prev;
  assign pre_tick = psa ? wdt_edge : tmr_tick_in;
  assign pre_clr  = do_wclr & psa;
  assign wdt_inc  = psa ? (wdt_edge && prescaler_out == 8'hff) : wdt_edge;
  assign wdt_ovf  = wdt_inc & (wdt_count_out == 8'hff) & ~do_wclr;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prescaler_out <= 8'h00;
    end else if (pre_clr) begin
      prescaler_out <= 8'h00;
    end else if (pre_tick) begin
      prescaler_out <= prescaler_out + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wdt_count_out <= 8'h00;
    end else if (do_wclr) begin
      wdt_count_out <= 8'h00;
    end else if (wdt_inc) begin
      wdt_count_out <= wdt_count_out + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_out <= `CWF_ST_RESET;
    end else begin
      if (bus_wr_in && bus_addr_in == `CWF_ADDR_STATUS) begin
        status_out <= bus_wdata_in;
      end
      // Call and decrement-skip never reach these branches
      if (take && alu_z_upd) begin
        status_out[`CWF_ST_Z] <= alu_zero;
      end
      if (do_wclr) begin
        status_out[`CWF_ST_TMO_N] <= 1'b1;
        status_out[`CWF_ST_PWD_N] <= 1'b1;
      end
      // A clear in the same cycle suppresses the timeout
      if (wdt_ovf) begin
        status_out[`CWF_ST_TMO_N] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl <= `CWF_CTRL_RESET;
    end else if (bus_wr_in && bus_addr_in == `CWF_ADDR_CTRL) begin
      ctrl <= {7'h00, bus_wdata_in[`CWF_CTRL_PSA]};
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_rdata_out <= 8'h00;
    end else if (!bus_rd_in) begin
      bus_rdata_out <= 8'h00;
    end else if (bus_addr_in <= `CWF_ADDR_FILE_TOP) begin
      bus_rdata_out <= file_mem[bus_addr_in[4:0]];
    end else begin
      case (bus_addr_in)
        `CWF_ADDR_ACC: begin
          bus_rdata_out <= w_out;
        end
        `CWF_ADDR_STATUS: begin
          bus_rdata_out <= status_out;
        end
        `CWF_ADDR_PC_LO: begin
          bus_rdata_out <= pc_out[7:0];
        end
        `CWF_ADDR_PC_HI: begin
          bus_rdata_out <= {5'h00, pc_out[PC_W-1:8]};
        end
        `CWF_ADDR_WDT: begin
          bus_rdata_out <= wdt_count_out;
        end
        `CWF_ADDR_PRESC: begin
          bus_rdata_out <= prescaler_out;
        end
        `CWF_ADDR_CTRL: begin
          bus_rdata_out <= ctrl;
        end
        default: begin
          bus_rdata_out <= 8'h00;
        end
      endcase
    end
  end

endmodule // cwf_core

`default_nettype wire

// [hw/cwf_file_alu.sv]
`timescale 1ns/100ps
`default_nettype none

module cwf_file_alu
  import cwf_pkg::*;
(
  input  wire cwf_op_t    op_in,
  input  wire logic [7:0] operand_in,
  output var  logic [7:0] result_out,
  output var  logic       zero_out,
  output var  logic       z_upd_out,
  output var  logic       is_file_op_out
);

  // ----------------------------------------------------------------
  // Result and zero detect
  // ----------------------------------------------------------------
  always_comb begin
    result_out     = operand_in;
    z_upd_out      = 1'b0;
    is_file_op_out = 1'b1;
    case (op_in)
      CWF_OP_CLR: begin
        result_out = 8'h00;
        z_upd_out  = 1'b1;
      end
      CWF_OP_INV: begin
        result_out = ~operand_in;
        z_upd_out  = 1'b1;
      end
      CWF_OP_DEC: begin
        result_out = operand_in - 8'h01;
        z_upd_out  = 1'b1;
      end
      CWF_OP_INC: begin
        result_out = operand_in + 8'h01;
        z_upd_out  = 1'b1;
      end
      CWF_OP_DECSZ: begin
        // Flags stay as they are; the zero test only steers the skip
        result_out = operand_in - 8'h01;
      end
      default: begin
        is_file_op_out = 1'b0;
      end
    endcase
    zero_out = (result_out == 8'h00);
  end

endmodule // cwf_file_alu

`default_nettype wire

// [inc/cwf_map.svh]
`ifndef CWF_MAP_SVH
`define CWF_MAP_SVH

// ----------------------------------------------------------------
// Instruction encodings (mask, value)
// ----------------------------------------------------------------
`define CWF_ENC_CALL_MASK   12'hf00
`define CWF_ENC_CALL_VAL    12'h900
`define CWF_ENC_WCLR_VAL    12'h004
`define CWF_ENC_CLR_MASK    12'hfe0
`define CWF_ENC_CLR_VAL     12'h060
`define CWF_ENC_FOP_MASK    12'hfc0
`define CWF_ENC_INV_VAL     12'h240
`define CWF_ENC_DEC_VAL     12'h0c0
`define CWF_ENC_INC_VAL     12'h280
`define CWF_ENC_DECSZ_VAL   12'h2c0

// ----------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------
`define CWF_DEST_BIT        5
`define CWF_FA_MSB          4
`define CWF_LIT_MSB         7

// ----------------------------------------------------------------
// Status fields and reset value
// ----------------------------------------------------------------
`define CWF_ST_Z            2
`define CWF_ST_PWD_N        3
`define CWF_ST_TMO_N        4
`define CWF_ST_PG_LSB       5
`define CWF_ST_PG_MSB       6
`define CWF_ST_RESET        8'h18
`define CWF_PC_BIT8         8

// ----------------------------------------------------------------
// Register port map
// ----------------------------------------------------------------
`define CWF_ADDR_FILE_TOP   6'h1f
`define CWF_ADDR_ACC        6'h20
`define CWF_ADDR_STATUS     6'h21
`define CWF_ADDR_PC_LO      6'h22
`define CWF_ADDR_PC_HI      6'h23
`define CWF_ADDR_WDT        6'h24
`define CWF_ADDR_PRESC      6'h25
`define CWF_ADDR_CTRL       6'h26
`define CWF_CTRL_PSA        0
`define CWF_CTRL_RESET      8'h01

`endif

// [inc/cwf_pkg.sv]
`default_nettype none

package cwf_pkg;

  typedef enum logic [2:0] {
    CWF_OP_NOP   = 3'b000,
    CWF_OP_CALL  = 3'b001,
    CWF_OP_WCLR  = 3'b010,
    CWF_OP_CLR   = 3'b011,
    CWF_OP_INV   = 3'b100,
    CWF_OP_DEC   = 3'b101,
    CWF_OP_INC   = 3'b110,
    CWF_OP_DECSZ = 3'b111
  } cwf_op_t;

endpackage : cwf_pkg

`default_nettype wire

// [sim/cwf_core_asserts.sv]
`timescale 1ns/100ps
`default_nettype none

module cwf_core_asserts
  import cwf_pkg::*;
#(
  parameter int PC_W = 11
)(
  input wire logic            sys_clk_in,
  input wire logic            sys_rst_in,
  input wire logic [11:0]     instr_in,
  input wire logic            instr_valid_in,
  input wire logic            instr_ready_out,
  input wire logic            flush_out,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic [PC_W-1:0] stack_top_out,
  input wire logic [7:0]      w_out,
  input wire logic [7:0]      status_out,
  input wire logic [7:0]      wdt_count_out
);
  // ----------------------------------------------------------------
  // Taken instructions
  // ----------------------------------------------------------------
  wire logic tk  = instr_valid_in & instr_ready_out;
  wire logic cl  = tk && ((instr_in & 12'hf00) == 12'h900);
  wire logic wc  = tk && (instr_in == 12'h004);
  wire logic cf  = tk && ((instr_in & 12'hfe0) == 12'h060);
  wire logic ds  = tk && ((instr_in & 12'hfc0) == 12'h2c0);
  wire logic ds0 = tk && ((instr_in & 12'hfe0) == 12'h2c0);
  wire logic ic0 = tk && ((instr_in & 12'hfe0) == 12'h280);

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_call_target: assert property (
    cl |=> pc_out == {$past(status_out[6:5]), 1'b0, $past(instr_in[7:0])})
    else $error("call target wrong");
  a_call_push: assert property (
    cl |=> stack_top_out == $past(pc_out) + 11'h1)
    else $error("call return address wrong");
  a_call_stall: assert property (
    cl |=> (flush_out && !instr_ready_out) ##1 instr_ready_out)
    else $error("call not two cycles");
  a_call_flags: assert property (cl |=> $stable(status_out))
    else $error("call changed status");
  a_wdog_clear: assert property (
    wc |=> wdt_count_out == 8'h00 && status_out[4:3] == 2'b11)
    else $error("watchdog clear wrong");
  a_clr_zero: assert property (cf |=> status_out[2])
    else $error("clear left zero flag low");
  a_skip_flags: assert property (ds |=> $stable(status_out))
    else $error("skip decrement changed status");
  a_skip_pc: assert property (
    ds |=> pc_out == $past(pc_out) + (flush_out ? 11'h2 : 11'h1))
    else $error("skip counter step wrong");
  a_skip_zero: assert property (
    ds0 |=> flush_out == (w_out == 8'h00))
    else $error("skip not tied to zero result");
  a_inc_zero: assert property (
    ic0 |=> status_out[2] == (w_out == 8'h00))
    else $error("increment zero flag wrong");
endmodule // cwf_core_asserts

bind cwf_core cwf_core_asserts #(.PC_W(PC_W)) u_chk (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .instr_in(instr_in),
  .instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out),
  .flush_out(flush_out), .pc_out(pc_out), .stack_top_out(stack_top_out),
  .w_out(w_out), .status_out(status_out), .wdt_count_out(wdt_count_out));

`default_nettype wire

// [sim/tb_cwf_core.sv]
`timescale 1ns/100ps
`default_nettype none

module tb_cwf_core
  import cwf_pkg::*;
;
  typedef struct packed {
    logic [4:0]  fa;
    logic [7:0]  iv;
    logic [11:0] op;
    logic [7:0]  st;
    logic [7:0]  ew;
    logic [7:0]  ef;
    logic [7:0]  es;
  } cwf_row_t;

  logic        sys_clk_in     = 1'b0;
  logic        sys_rst_in     = 1'b1;
  logic [11:0] instr_in       = 12'h000;
  logic        instr_valid_in = 1'b0;
  logic        wdt_tick_in    = 1'b0;
  logic        tmr_tick_in    = 1'b0;
  logic [5:0]  bus_addr_in    = 6'h00;
  logic [7:0]  bus_wdata_in   = 8'h00;
  logic        bus_wr_in      = 1'b0;
  logic        bus_rd_in      = 1'b0;
  logic        instr_ready_out;
  logic        flush_out;
  logic [10:0] pc_out;
  logic [10:0] stack_top_out;
  logic [7:0]  w_out;
  logic [7:0]  status_out;
  logic [7:0]  wdt_count_out;
  logic [7:0]  prescaler_out;
  logic [7:0]  bus_rdata_out;
  int          failures = 0;
  int          n_checks = 0;
  logic [10:0] epc;
  // Accumulator is preset to 5a, so d=1 rows expect it untouched
  cwf_row_t rows [11] = '{
    '{5'h07, 8'h3c, 12'h067, 8'h18, 8'h5a, 8'h00, 8'h1c},
    '{5'h1f, 8'hff, 12'h27f, 8'h18, 8'h5a, 8'h00, 8'h1c},
    '{5'h02, 8'h0f, 12'h242, 8'h1c, 8'hf0, 8'h0f, 8'h18},
    '{5'h04, 8'h00, 12'h0e4, 8'h1c, 8'h5a, 8'hff, 8'h18},
    '{5'h05, 8'h01, 12'h0c5, 8'h18, 8'h00, 8'h01, 8'h1c},
    '{5'h06, 8'hff, 12'h286, 8'h18, 8'h00, 8'hff, 8'h1c},
    '{5'h08, 8'h7f, 12'h2a8, 8'h1c, 8'h5a, 8'h80, 8'h18},
    '{5'h09, 8'h05, 12'h2e9, 8'h1c, 8'h5a, 8'h04, 8'h1c},
    '{5'h0a, 8'h00, 12'h2ea, 8'h18, 8'h5a, 8'hff, 8'h18},
    '{5'h0c, 8'h03, 12'h2cc, 8'h18, 8'h02, 8'h03, 8'h18},
    '{5'h0d, 8'h33, 12'h000, 8'h1c, 8'h5a, 8'h33, 8'h1c}};

  cwf_core u_dut (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .wdt_tick_in(wdt_tick_in),
    .tmr_tick_in(tmr_tick_in), .bus_addr_in(bus_addr_in),
    .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in),
    .bus_rd_in(bus_rd_in), .instr_ready_out(instr_ready_out),
    .flush_out(flush_out), .pc_out(pc_out), .stack_top_out(stack_top_out),
    .w_out(w_out), .status_out(status_out), .wdt_count_out(wdt_count_out),
    .prescaler_out(prescaler_out), .bus_rdata_out(bus_rdata_out));

  always #5 sys_clk_in = ~sys_clk_in;

  // ----------------------------------------------------------------
  // Drivers and compare
  // ----------------------------------------------------------------
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    bus_addr_in  <= a;
    bus_wdata_in <= d;
    bus_wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    bus_wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    bus_addr_in <= a;
    bus_rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    bus_rd_in   <= 1'b0;
    @(negedge sys_clk_in);
    chk(bus_rdata_out, e);
  endtask

  // Ready is judged at the falling edge, where it has settled
  task automatic ex(input logic [11:0] w);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    instr_in       <= w;
    instr_valid_in <= 1'b1;
    @(negedge sys_clk_in);
    while (instr_ready_out !== 1'b1) begin
      n++;
      if (n > 8) begin
        failures++;
        conclude();
      end
      @(negedge sys_clk_in);
    end
    @(posedge sys_clk_in);
    instr_valid_in <= 1'b0;
    @(negedge sys_clk_in);
  endtask

  // Long high and low phases so the two-flop sync sees every edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      wdt_tick_in <= 1'b1;
      tmr_tick_in <= 1'b1;
      @(posedge sys_clk_in);
      tmr_tick_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      wdt_tick_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
    end
    @(negedge sys_clk_in);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    chk(pc_out, 11'h000);
    chk(status_out, 8'h18);
    chk(w_out | wdt_count_out | prescaler_out, 8'h00);
    chk({flush_out, instr_ready_out, bus_rdata_out}, 10'h000);
    chk(stack_top_out, 11'h000);
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rd(6'h26, 8'h01);
    wr(6'h3f, 8'h77);
    rd(6'h3f, 8'h00);
    wr(6'h22, 8'h55);
    rd(6'h22, 8'h00);
    epc = 11'h000;
    foreach (rows[i]) begin
      wr(6'h20, 8'h5a);
      wr(6'h21, rows[i].st);
      wr({1'b0, rows[i].fa}, rows[i].iv);
      ex(rows[i].op);
      epc++;
      chk(w_out, rows[i].ew);
      chk(status_out, rows[i].es);
      chk(pc_out, epc);
      rd({1'b0, rows[i].fa}, rows[i].ef);
    end
    wr(6'h21, 8'h58);
    ex(12'h9ab);
    chk(pc_out, 11'h4ab);
    chk(stack_top_out, epc + 11'h1);
    chk({flush_out, instr_ready_out}, 2'b10);
    chk(status_out, 8'h58);
    wr(6'h21, 8'h38);
    ex(12'h9ff);
    chk(pc_out, 11'h2ff);
    chk(stack_top_out, 11'h4ac);
    wr(6'h0b, 8'h01);
    ex(12'h2eb);
    chk(pc_out, 11'h301);
    chk({flush_out, instr_ready_out}, 2'b10);
    chk(status_out, 8'h38);
    rd(6'h0b, 8'h00);
    wr(6'h21, 8'h00);
    tick(3);
    chk(prescaler_out, 8'h03);
    ex(12'h004);
    chk(prescaler_out, 8'h00);
    chk(status_out, 8'h18);
    wr(6'h26, 8'h00);
    tick(3);
    chk(wdt_count_out, 8'h03);
    ex(12'h004);
    chk(wdt_count_out, 8'h00);
    chk(prescaler_out, 8'h03);
    // Mid-run reset must bring back every reset value
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b1;
    @(negedge sys_clk_in);
    chk({flush_out, instr_ready_out, bus_rdata_out}, 10'h000);
    chk(pc_out | stack_top_out, 11'h000);
    chk(w_out | wdt_count_out | prescaler_out, 8'h00);
    chk(status_out, 8'h18);
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rd(6'h08, 8'h00);
    rd(6'h26, 8'h01);
    ex(12'h000);
    chk(pc_out, 11'h001);
    conclude();
  end
endmodule // tb_cwf_core

`default_nettype wire
